// file: src/gpi_port.sv
// Two banks of GPIO pins with configuration, de-bounce, edge flags and APB slave
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module gpi_port import gpi_pkg::*; #(
  parameter int PINS = 2,
  parameter int SLOW_PERIOD = SLOW_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pin side, one bit per bank
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] port_data_out,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] high_side_drive_en,
  output logic [PINS-1:0] low_side_drive_en,
  output logic [PINS-1:0] fast_drive_en,
  output logic [PINS-1:0] analog_node_a_en,
  output logic [PINS-1:0] analog_node_b_en,
  output logic [PINS-1:0] pullup_en,
  output logic [PINS-1:0] pulldown_en,
  // Core side
  output logic [PINS-1:0] port_data_in,
  output logic [PINS*8-1:0] pin_function_sel,
  output logic ext_irq0,
  output logic ext_irq1
);

  localparam logic [15:0] OUT_ADDR [2] = '{OUT_CFG_A_ADDR, OUT_CFG_B_ADDR};
  localparam logic [15:0] IN_ADDR [2] = '{IN_CFG_A_ADDR, IN_CFG_B_ADDR};
  localparam logic [15:0] FN_ADDR [2] = '{FUNC_SEL_A_ADDR, FUNC_SEL_B_ADDR};

  function automatic logic [6:0] debounce_len(input logic [1:0] sel);
    unique case (sel)
      2'b01: debounce_len = DEBOUNCE_4;
      2'b10: debounce_len = DEBOUNCE_16;
      2'b11: debounce_len = DEBOUNCE_64;
      default: debounce_len = 7'h00;
    endcase
  endfunction : debounce_len

  // Slow clock tick from one free-running divider
  logic [15:0] slow_cnt_r;
  logic slow_tick;
  assign slow_tick = (slow_cnt_r == 16'(SLOW_PERIOD - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_cnt_r <= 16'h0000;
    end else begin
      slow_cnt_r <= slow_tick ? 16'h0000 : slow_cnt_r + 16'h0001;
    end
  end

  wire access = psel && penable;
  wire wr = access && pwrite;
  assign pready = 1'b1;

  logic [PINS-1:0] hit;
  logic [PINS*32-1:0] rd_bus;
  logic [PINS-1:0] irq1_src;
  logic [PINS-1:0] irq0_src;

  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic [7:0] out_cfg_r;
      logic [7:0] in_cfg_r;
      logic [7:0] fn_r;
      logic [1:0] dbn_r;
      logic rise_r, fall_r;
      logic filt_r, filt_d_r;
      logic [6:0] stab_r;
      logic cand_r;
      wire hit_out = (paddr == OUT_ADDR[g]);
      wire hit_in = (paddr == IN_ADDR[g]);
      wire hit_fn = (paddr == FN_ADDR[g]);
      assign hit[g] = hit_out || hit_in || hit_fn;

      wire buf_lvl = in_cfg_r[IN_BUF_BIT] & pin_in[g];
      wire raw = buf_lvl ^ in_cfg_r[IN_INV_BIT];
      wire [6:0] need = debounce_len(dbn_r);
      wire filt_nxt_off = raw;

      // Filter: level must hold for the selected count of slow ticks
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          filt_r <= 1'b0;
          cand_r <= 1'b0;
          stab_r <= 7'h00;
        end else if (need == 7'h00) begin
          filt_r <= filt_nxt_off;
          cand_r <= raw;
          stab_r <= 7'h00;
        end else if (raw != cand_r) begin
          cand_r <= raw;
          stab_r <= 7'h00;
        end else if (slow_tick) begin
          if (stab_r + 7'h01 >= need) begin
            filt_r <= cand_r;
          end else begin
            stab_r <= stab_r + 7'h01;
          end
        end
      end

      wire routed = in_cfg_r[IRQ1_ROUTE_BIT] | in_cfg_r[IRQ0_ROUTE_BIT];
      wire rise_ev = filt_r & ~filt_d_r & routed & in_cfg_r[RISE_BIT];
      wire fall_ev = ~filt_r & filt_d_r & routed & in_cfg_r[FALL_BIT];
      wire wr_in = wr && hit_in;

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          out_cfg_r <= OUT_CFG_RESET;
          in_cfg_r <= IN_CFG_RESET;
          fn_r <= FUNC_SEL_RESET;
          dbn_r <= 2'b00;
          filt_d_r <= 1'b0;
          rise_r <= 1'b0;
          fall_r <= 1'b0;
        end else begin
          filt_d_r <= filt_r;
          if (wr && hit_out) out_cfg_r <= pwdata[7:0];
          if (wr && hit_fn) fn_r <= pwdata[7:0];
          if (wr_in) begin
            in_cfg_r <= {pwdata[7:2], 2'b00};
            dbn_r <= pwdata[1:0];
          end
          // Set wins over a same-cycle clear
          if (rise_ev) rise_r <= 1'b1;
          else if (wr_in && !pwdata[RISE_BIT]) rise_r <= 1'b0;
          if (fall_ev) fall_r <= 1'b1;
          else if (wr_in && !pwdata[FALL_BIT]) fall_r <= 1'b0;
        end
      end

      wire [7:0] in_rd = {in_cfg_r[7:6], rise_r, fall_r, in_cfg_r[3:2], filt_r, buf_lvl};
      assign rd_bus[g*32 +: 32] = hit_out ? {24'h000000, out_cfg_r} :
                                  hit_in ? {24'h000000, in_rd} :
                                  hit_fn ? {24'h000000, fn_r} : 32'h00000000;

      assign pin_out[g] = port_data_out[g] ^ out_cfg_r[OUT_INV_BIT];
      assign high_side_drive_en[g] = out_cfg_r[HIGH_SIDE_BIT];
      assign low_side_drive_en[g] = out_cfg_r[LOW_SIDE_BIT];
      assign fast_drive_en[g] = out_cfg_r[FAST_DRIVE_BIT];
      assign analog_node_b_en[g] = out_cfg_r[TAP_B_BIT];
      assign analog_node_a_en[g] = out_cfg_r[TAP_A_BIT];
      assign pullup_en[g] = out_cfg_r[PULLUP_BIT];
      assign pulldown_en[g] = out_cfg_r[PULLDOWN_BIT];
      assign port_data_in[g] = filt_r;
      assign pin_function_sel[g*8 +: 8] = fn_r;
      assign irq1_src[g] = (rise_r | fall_r) & in_cfg_r[IRQ1_ROUTE_BIT];
      assign irq0_src[g] = (rise_r | fall_r) & in_cfg_r[IRQ0_ROUTE_BIT];
    end
  endgenerate

  assign ext_irq1 = |irq1_src;
  assign ext_irq0 = |irq0_src;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    for (int i = 0; i < PINS; i++) rd_mux = rd_mux | rd_bus[i*32 +: 32];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign pslverr = access && !(|hit);

endmodule : gpi_port

// file: src/gpi_pkg.sv
// Package with register map, field positions and timing constants for the pin port
package gpi_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [15:0] OUT_CFG_A_ADDR = 16'ha100;
  localparam logic [15:0] IN_CFG_A_ADDR = 16'ha110;
  localparam logic [15:0] FUNC_SEL_A_ADDR = 16'ha120;
  localparam logic [15:0] OUT_CFG_B_ADDR = 16'ha130;
  localparam logic [15:0] IN_CFG_B_ADDR = 16'ha140;
  localparam logic [15:0] FUNC_SEL_B_ADDR = 16'ha150;
  localparam logic [7:0] OUT_CFG_RESET = 8'h00;
  localparam logic [7:0] IN_CFG_RESET = 8'h00;
  localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
  // Output configuration fields
  localparam int FAST_DRIVE_BIT = 7;
  localparam int HIGH_SIDE_BIT = 6;
  localparam int LOW_SIDE_BIT = 5;
  localparam int OUT_INV_BIT = 4;
  localparam int TAP_B_BIT = 3;
  localparam int TAP_A_BIT = 2;
  localparam int PULLUP_BIT = 1;
  localparam int PULLDOWN_BIT = 0;
  // Input configuration fields
  localparam int IRQ1_ROUTE_BIT = 7;
  localparam int IRQ0_ROUTE_BIT = 6;
  localparam int RISE_BIT = 5;
  localparam int FALL_BIT = 4;
  localparam int IN_BUF_BIT = 3;
  localparam int IN_INV_BIT = 2;
  localparam int FILT_LEVEL_BIT = 1;
  localparam int RAW_LEVEL_BIT = 0;
  // Time base: 128 kHz slow oscillator divided by four
  localparam int CLK_HZ = 40000000;
  localparam int SLOW_OSC_HZ = 128000;
  localparam int SLOW_CLK_HZ = 32000;
  localparam int SLOW_DIV = SLOW_OSC_HZ / SLOW_CLK_HZ;
  localparam int SLOW_PERIOD_CYCLES = CLK_HZ / SLOW_CLK_HZ;
  localparam logic [6:0] DEBOUNCE_4 = 7'h04;
  localparam logic [6:0] DEBOUNCE_16 = 7'h10;
  localparam logic [6:0] DEBOUNCE_64 = 7'h40;
endpackage : gpi_pkg

// file: dv/gpi_port_asserts.sv
// Port checker for the pin port, bound to its top module
`timescale 1ns/1ps
module gpi_port_asserts import gpi_pkg::*; #(parameter int PINS = 2) (
  // APB side
  input logic clk, input logic reset_n, input logic psel, input logic penable, input logic pwrite,
  input logic [15:0] paddr, input logic [31:0] pwdata, input logic [31:0] prdata,
  // Pin and core side
  input logic [PINS-1:0] port_data_out, input logic [PINS-1:0] pin_out, input logic [PINS-1:0] port_data_in,
  input logic [PINS-1:0] high_side_drive_en, input logic [PINS-1:0] low_side_drive_en,
  input logic [PINS-1:0] fast_drive_en, input logic [PINS-1:0] analog_node_a_en,
  input logic [PINS-1:0] analog_node_b_en, input logic [PINS-1:0] pullup_en, input logic [PINS-1:0] pulldown_en,
  input logic [PINS*8-1:0] pin_function_sel, input logic ext_irq0
);
  wire wr_go = psel && penable && pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_hiz_reset: assert property ($rose(reset_n) |-> high_side_drive_en == '0 && low_side_drive_en == '0)
    else $error("drivers on after reset");
  a_drv_hold: assert property (!wr_go |=> $stable(high_side_drive_en) && $stable(low_side_drive_en))
    else $error("drivers changed without a write");
  a_drive_bits: assert property (wr_go && paddr == OUT_CFG_B_ADDR |=> {fast_drive_en[1], high_side_drive_en[1],
    low_side_drive_en[1], analog_node_b_en[1], analog_node_a_en[1], pullup_en[1], pulldown_en[1]}
    == {$past(pwdata[7:5]), $past(pwdata[3:0])}) else $error("bank b output stage wrong");
  a_out_invert: assert property (wr_go && paddr == OUT_CFG_A_ADDR |=> pin_out[0] == (port_data_out[0]
    ^ $past(pwdata[OUT_INV_BIT])) && {high_side_drive_en[0], low_side_drive_en[0]} == $past(pwdata[6:5]))
    else $error("bank a drive or polarity wrong");
  a_func_write: assert property (wr_go && paddr == FUNC_SEL_B_ADDR |=> pin_function_sel[15:8] == $past(pwdata[7:0]))
    else $error("function select not written");
  a_func_hold: assert property (!wr_go |=> $stable(pin_function_sel))
    else $error("function select changed alone");
  a_irq_edge: assert property ($rose(ext_irq0) |-> $changed(port_data_in) || $past(port_data_in) != $past(port_data_in, 2))
    else $error("interrupt without input edge");
  a_prdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved outside a read");
endmodule : gpi_port_asserts
bind gpi_port gpi_port_asserts #(.PINS(PINS)) u_asserts (.*);

// file: dv/gpi_board.sv
// Board model: drives or pulls each pin as the port's output stage allows
`timescale 1ns/1ps
module gpi_board #(parameter int PINS = 2) (
  // Port output stage
  input logic clk, input logic [PINS-1:0] pin_out, input logic [PINS-1:0] high_side_drive_en,
  input logic [PINS-1:0] low_side_drive_en, input logic [PINS-1:0] pullup_en, input logic [PINS-1:0] pulldown_en,
  // Pin level seen by the port
  output logic [PINS-1:0] pin_in
);
  logic [PINS-1:0] float_r = '0;
  // A floating pin wanders every cycle
  always @(posedge clk) float_r <= ~float_r;
  always_comb for (int i = 0; i < PINS; i++) pin_in[i] = (high_side_drive_en[i] && pin_out[i]) ? 1'b1 :
    (low_side_drive_en[i] && !pin_out[i]) ? 1'b0 : pullup_en[i] ? 1'b1 : pulldown_en[i] ? 1'b0 : float_r[i];
endmodule : gpi_board

// file: dv/test_gpi_port.sv
// Self-checking bench for the pin port with a board model on the pins
`timescale 1ns/1ps
module test_gpi_port import gpi_pkg::*;;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ext_irq0, ext_irq1;
  logic [15:0] paddr = '0, pin_function_sel;
  logic [31:0] pwdata = '0, prdata;
  logic [1:0] pin_in, port_data_out = '0, pin_out, high_side_drive_en, low_side_drive_en, fast_drive_en;
  logic [1:0] analog_node_a_en, analog_node_b_en, pullup_en, pulldown_en, port_data_in;
  logic [32:0] exp_q[$], msk_q[$];
  int fail_count = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  gpi_port #(.SLOW_PERIOD(4)) dut (.*);
  gpi_board board (.*);
  task automatic chk(string what, logic [32:0] e, logic [32:0] g, logic [32:0] m);
    total_checks++;
    if ((g & m) !== (e & m)) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e & m, g & m);
    end
  endtask : chk
  // Reads are judged when the access phase completes
  always @(posedge clk) if (psel && penable && pready && !pwrite) chk("read", exp_q.pop_front(), {pslverr, prdata},
    msk_q.pop_front());
  task automatic apb(logic wr, logic [15:0] a, logic [7:0] d, logic [32:0] e = '0, logic [32:0] m = '0);
    if (!wr) exp_q.push_back(e);
    if (!wr) msk_q.push_back(m);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wait_rd(int n, logic [15:0] a, logic [7:0] e, logic [32:0] m);
    repeat (n) @(posedge clk);
    apb(0, a, 0, {25'h0, e}, m);
  endtask : wait_rd
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    logic [7:0] r;
    logic lv;
    logic [15:0] rw_a[4];
    rw_a = '{OUT_CFG_A_ADDR, FUNC_SEL_A_ADDR, OUT_CFG_B_ADDR, FUNC_SEL_B_ADDR};
    r = 8'($urandom(55599));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) apb(0, OUT_CFG_A_ADDR + 16'(16 * i), 0, '0, '1);
    apb(1, 16'ha104, 8'hff);
    apb(0, 16'ha104, 0, 33'h100000000, '1);
    repeat (3) foreach (rw_a[i]) begin
      r = 8'($urandom);
      apb(1, rw_a[i], r);
      apb(0, rw_a[i], 0, {25'h0, r}, '1);
      port_data_out <= 2'($urandom);
    end
    apb(1, OUT_CFG_A_ADDR, 8'h60);
    apb(1, OUT_CFG_B_ADDR, 8'h60);
    port_data_out <= 2'b00;
    apb(1, IN_CFG_A_ADDR, 8'h78);
    port_data_out[0] <= 1'b1;
    wait_rd(4, IN_CFG_A_ADDR, 8'h6b, '1);
    chk("irq0", 1, ext_irq0, 1);
    chk("irq1", 0, ext_irq1, 1);
    port_data_out[0] <= 1'b0;
    wait_rd(4, IN_CFG_A_ADDR, 8'h78, '1);
    apb(1, IN_CFG_A_ADDR, 8'h48);
    wait_rd(1, IN_CFG_A_ADDR, 8'h48, '1);
    chk("irq0", 0, ext_irq0, 1);
    apb(1, IN_CFG_A_ADDR, 8'h4c);
    wait_rd(4, IN_CFG_A_ADDR, 8'h4e, '1);
    apb(1, IN_CFG_A_ADDR, 8'h44);
    port_data_out[0] <= 1'b1;
    wait_rd(4, IN_CFG_A_ADDR, 8'h46, '1);
    apb(1, IN_CFG_B_ADDR, 8'h08);
    for (int s = 1; s < 4; s++) begin
      apb(1, IN_CFG_B_ADDR, 8'(8 + s));
      repeat (300) @(posedge clk);
      lv = ~port_data_out[1];
      port_data_out[1] <= lv;
      wait_rd(2 << (2 * s), IN_CFG_B_ADDR, {6'h0, ~lv, 1'b0}, 33'h2);
      wait_rd(8 << (2 * s), IN_CFG_B_ADDR, {6'h0, lv, 1'b0}, 33'h2);
    end
    tally_and_finish;
  end
endmodule : test_gpi_port
